// ===== bench/bcx_testbench.sv
/*
 * Self-checking testbench for bcx_core: drives APB and the port pins, checks results.
 * Assumes the core's APB timing, register map and file address map as handed over.
 */
`timescale 1ns/1ns
module testbench;
	import bcx_pkg::*;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic        pready;
	logic        pslverr;
	logic        presc_clr;
	logic        rd_err;
	logic [7:0]  paddr;
	logic [7:0]  port_in;
	logic [7:0]  port_out;
	logic [7:0]  port_oe;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] rd_val;
	int          error_cnt = 0;
	int          cmp_count = 0;
	int          cyc       = 0;
	int          clr_cnt   = 0;

	bcx_core bcx_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.port_in(port_in), .port_out(port_out), .port_oe(port_oe), .presc_clr(presc_clr));

	// ----------------------------------------------------------------
	// Clock, pulse counter and timeout
	// ----------------------------------------------------------------
	always #25 pclk = ~pclk;

	always @(posedge pclk)
	begin
		cyc++;
		if (presc_clr === 1'b1)
			clr_cnt++;
		if (cyc == 20000)
		begin
			error_cnt++;
			print_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1);
		chk("apb wait edges", n, 32'd3);
		rd_val = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(name, rd_val, exp);
	endtask : rdchk

	task automatic ex(input logic [11:0] i);
		apb(1'b1, OFS_INSTR, {20'h0, i});
	endtask : ex

	task automatic setw(input logic [7:0] v);
		apb(1'b1, OFS_ACC, {24'h0, v});
	endtask : setw

	task automatic setf(input logic [4:0] f, input logic [7:0] v);
		apb(1'b1, OFS_FADDR, {27'h0, f});
		apb(1'b1, OFS_FDATA, {24'h0, v});
	endtask : setf

	task automatic getf(input string name, input logic [4:0] f, input logic [7:0] exp);
		apb(1'b1, OFS_FADDR, {27'h0, f});
		rdchk(name, OFS_FDATA, {24'h0, exp});
	endtask : getf

	function automatic logic [11:0] fop(input logic [5:0] op, input logic d, input logic [4:0] f);
		return {op, d, f};
	endfunction : fop

	function automatic logic [11:0] bop(input logic [3:0] op, input logic [2:0] b, input logic [4:0] f);
		return {op, b, f};
	endfunction : bop

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		chk("port_oe", {24'h0, port_oe}, 32'h0);
		chk("port_out", {24'h0, port_out}, 32'h0);
		rdchk("acc", OFS_ACC, 32'h0);
		rdchk("pc", OFS_PC, 32'h0);
		rdchk("status", OFS_STATUS, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk("pslverr", {31'h0, rd_err}, 32'h1);
		$display("t_reset done");
	endtask : t_reset

	task automatic t_add;
		logic [7:0] wv [3] = '{8'h0f, 8'h80, 8'h3c};
		logic [7:0] fv [3] = '{8'h01, 8'h80, 8'h41};
		logic [8:0] s;
		logic [4:0] lo;
		for (int i = 0; i < 6; i++)
		begin
			setw(wv[i/2]);
			setf(5'h10, fv[i/2]);
			ex(fop(OPC_ADD_FILE, i[0], 5'h10));
			s = wv[i/2] + fv[i/2];
			lo = wv[i/2][3:0] + fv[i/2][3:0];
			rdchk("add acc", OFS_ACC, {24'h0, i[0] ? wv[i/2] : s[7:0]});
			getf("add file", 5'h10, i[0] ? s[7:0] : fv[i/2]);
			rdchk("add status", OFS_STATUS, {29'h0, s[7:0] == 8'h0, lo[4], s[8]});
		end
		$display("t_add done");
	endtask : t_add

	task automatic t_and;
		logic [7:0] k [3] = '{8'hff, 8'h5a, 8'h00};
		setw(8'h80);
		setf(5'h10, 8'h80);
		ex(fop(OPC_ADD_FILE, 1'b0, 5'h10));
		setw(8'hf0);
		setf(5'h10, 8'h3c);
		ex(fop(OPC_AND_FILE, 1'b1, 5'h10));
		getf("and file", 5'h10, 8'h30);
		rdchk("and acc", OFS_ACC, 32'hf0);
		rdchk("and status", OFS_STATUS, 32'h1);
		setf(5'h11, 8'h0f);
		ex(fop(OPC_AND_FILE, 1'b0, 5'h11));
		rdchk("and acc", OFS_ACC, 32'h0);
		getf("and file", 5'h11, 8'h0f);
		for (int i = 0; i < 3; i++)
		begin
			setw(8'ha5);
			ex({OPC_AND_LIT, k[i]});
			rdchk("andlit acc", OFS_ACC, {24'h0, 8'ha5 & k[i]});
			rdchk("andlit status", OFS_STATUS, {29'h0, (8'ha5 & k[i]) == 8'h0, 2'b01});
		end
		$display("t_and done");
	endtask : t_and

	task automatic t_bits;
		for (int b = 0; b < 8; b++)
		begin
			setf(5'h1f, 8'hff);
			ex(bop(OPC_BIT_CLR, b[2:0], 5'h1f));
			getf("bit clear", 5'h1f, ~(8'h01 << b));
			setf(5'h1f, 8'h00);
			ex(bop(OPC_BIT_SET, b[2:0], 5'h1f));
			getf("bit set", 5'h1f, 8'h01 << b);
			rdchk("bit status", OFS_STATUS, 32'h5);
		end
		$display("t_bits done");
	endtask : t_bits

	task automatic t_skip;
		logic [3:0]  ops [4] = '{OPC_TEST_CLR, OPC_TEST_CLR, OPC_TEST_SET, OPC_TEST_SET};
		logic [2:0]  bs [4]  = '{3'h0, 3'h1, 3'h1, 3'h0};
		logic [10:0] p0;
		setf(5'h13, 8'h02);
		for (int i = 0; i < 4; i++)
		begin
			setw(8'h5a);
			apb(1'b0, OFS_PC, 32'h0);
			p0 = rd_val[10:0];
			ex(bop(ops[i], bs[i], 5'h13));
			rdchk("skip flag", OFS_SKIP, {31'h0, ~i[0]});
			rdchk("test status", OFS_STATUS, 32'h5);
			ex({OPC_AND_LIT, 8'h00});
			rdchk("skip acc", OFS_ACC, i[0] ? 32'h0 : 32'h5a);
			rdchk("skip pc", OFS_PC, {21'h0, p0 + 11'd2});
			rdchk("skip clear", OFS_SKIP, 32'h0);
		end
		$display("t_skip done");
	endtask : t_skip

	task automatic t_pc;
		ex({OPC_BRANCH, 9'h1ff});
		rdchk("branch pc", OFS_PC, 32'h1ff);
		setw(8'h00);
		ex(fop(OPC_AND_FILE, 1'b1, FA_PCL));
		rdchk("pcl and pc", OFS_PC, 32'h000);
		ex({OPC_BRANCH, 9'h1ff});
		ex(bop(OPC_BIT_SET, 3'h0, FA_PCL));
		rdchk("pcl set pc", OFS_PC, 32'h0ff);
		$display("t_pc done");
	endtask : t_pc

	task automatic t_port;
		setw(8'ha5);
		ex(12'h006);
		chk("port_oe", {24'h0, port_oe}, 32'h5a);
		setw(8'h00);
		ex(12'h005);
		chk("port_oe", {24'h0, port_oe}, 32'h5a);
		ex(12'h006);
		chk("port_oe", {24'h0, port_oe}, 32'hff);
		port_in <= 8'h0f;
		setf(FA_PORT1, 8'hff);
		chk("port_out", {24'h0, port_out}, 32'hff);
		ex(bop(OPC_BIT_SET, 3'h7, FA_PORT1));
		chk("port_out", {24'h0, port_out}, 32'h8f);
		port_in <= 8'h3c;
		setw(8'hff);
		ex(fop(OPC_AND_FILE, 1'b1, FA_PORT1));
		chk("port_out", {24'h0, port_out}, 32'h3c);
		$display("t_port done");
	endtask : t_port

	task automatic t_presc;
		logic [11:0] ins [7];
		logic        cf [7]    = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
		int          n_exp [7] = '{1, 0, 1, 1, 1, 0, 0};
		int          c0;
		ins = '{fop(OPC_ADD_FILE, 1'b1, FA_TIMER), fop(OPC_ADD_FILE, 1'b0, FA_TIMER),
			fop(OPC_AND_FILE, 1'b1, FA_TIMER), bop(OPC_BIT_CLR, 3'h2, FA_TIMER),
			bop(OPC_BIT_SET, 3'h2, FA_TIMER), bop(OPC_BIT_SET, 3'h2, 5'h10),
			bop(OPC_BIT_SET, 3'h2, FA_TIMER)};
		for (int i = 0; i < 7; i++)
		begin
			apb(1'b1, OFS_CTRL, {31'h0, cf[i]});
			c0 = clr_cnt;
			ex(ins[i]);
			chk("presc pulses", clr_cnt - c0, n_exp[i]);
		end
		rdchk("ctrl", OFS_CTRL, 32'h0);
		rdchk("last instr", OFS_INSTR, {20'h0, ins[6]});
		$display("t_presc done");
	endtask : t_presc

	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		port_in = 8'h00;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_add();
		t_and();
		t_bits();
		t_skip();
		t_pc();
		t_port();
		t_presc();
		print_verdict();
	end
endmodule : testbench

// ===== hw/bcx_alu.sv
/*
 * Combinational 8-bit arithmetic and bit unit for the execute block.
 * Assumes the caller picks which of the returned flags it keeps.
 */
`timescale 1ns/1ns
module bcx_alu (
	input  bcx_pkg::bcx_op_e  op,
	input  wire logic [7:0]   acc,
	input  wire logic [7:0]   fval,
	input  wire logic [7:0]   lit,
	input  wire logic [2:0]   bsel,
	output bcx_pkg::bcx_alu_s res
);
	import bcx_pkg::*;

	logic [8:0] sum;
	logic [4:0] lo;
	logic [7:0] mask;

	// ----------------------------------------------------------------
	// Result and flags
	// ----------------------------------------------------------------
	always_comb
	begin
		sum    = {1'b0, acc} + {1'b0, fval};
		lo     = {1'b0, acc[3:0]} + {1'b0, fval[3:0]};
		mask   = 8'h01 << bsel;
		res.c  = sum[8];
		res.dc = lo[4];
		unique case (op)
			OP_ADD_FILE: res.res = sum[7:0];
			OP_AND_FILE: res.res = acc & fval;
			OP_AND_LIT:  res.res = acc & lit;
			OP_BIT_CLR:  res.res = fval & ~mask;
			OP_BIT_SET:  res.res = fval | mask;
			default:     res.res = fval;
		endcase
		res.z = (res.res == 8'h00);
	end

endmodule : bcx_alu

// ===== hw/bcx_core.sv
/*
 * Execute unit for a subset of a 12-bit baseline instruction set, driven over APB.
 * Software writes an instruction word to the instruction register and it executes.
 * Assumes one APB master, pins of the first I/O port synchronous to pclk.
 */
// Notes on behaviour
// - File writes to program counter low byte clear bit eight
// - Self-modifying port writes read the pins
// - Direction load six copies inverted accumulator to port output enables
// - Timer-target marked writes clear assigned prescaler
// - Add sets carry, digit carry, zero
// - Destination zero accumulator, one file register
// - Literal AND into accumulator, zero flag
// - File AND routed by destination bit
// - Bit clear keeps flags unchanged
// - Bit set keeps flags unchanged
// - Skip-when-clear discards next instruction
// - Skip-when-set discards next; flags untouched
`timescale 1ns/1ns
module bcx_core (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr,
	input  wire logic [7:0]  port_in,
	output logic      [7:0]  port_out,
	output logic      [7:0]  port_oe,
	output logic             presc_clr
);
	import bcx_pkg::*;

	bcx_core_s st_ff;
	bcx_core_s nxt_st;
	bcx_alu_s  alu;
	bcx_op_e   ex_op;
	logic [11:0] ex_instr;
	logic [4:0]  ex_f;
	logic        ex_d;
	logic [2:0]  ex_b;
	logic [7:0]  ex_k;
	logic        ex_to_file;
	logic        is_instr_wr;
	logic        exec;
	logic        access;
	logic        hit;
	logic [4:0]  rd_f;
	logic [7:0]  ram_rdata;
	logic [7:0]  fval;
	logic        wr_en;
	logic [4:0]  wr_addr;
	logic [7:0]  wr_data;
	logic        ram_we;
	logic        take_skip;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	function automatic bcx_op_e decode(input logic [11:0] i);
		if (i[11:6] == OPC_ADD_FILE)
			return OP_ADD_FILE;
		if (i[11:6] == OPC_AND_FILE)
			return OP_AND_FILE;
		if (i[11:8] == OPC_BIT_CLR)
			return OP_BIT_CLR;
		if (i[11:8] == OPC_BIT_SET)
			return OP_BIT_SET;
		if (i[11:8] == OPC_TEST_CLR)
			return OP_TEST_CLR;
		if (i[11:8] == OPC_TEST_SET)
			return OP_TEST_SET;
		if (i[11:8] == OPC_AND_LIT)
			return OP_AND_LIT;
		if (i[11:9] == OPC_BRANCH)
			return OP_BRANCH;
		if (i[11:3] == OPC_DIR_LOAD)
			return OP_DIR_LOAD;
		return OP_NONE;
	endfunction : decode

	assign access      = psel && penable;
	assign is_instr_wr = pwrite && (paddr == OFS_INSTR);
	assign exec        = access && is_instr_wr && (st_ff.state == ST_READ);
	assign ex_instr    = pwdata[11:0];
	assign ex_op       = st_ff.skip ? OP_NONE : decode(ex_instr);
	assign ex_f        = ex_instr[4:0];
	assign ex_d        = ex_instr[5];
	assign ex_b        = ex_instr[7:5];
	assign ex_k        = ex_instr[7:0];
	assign ex_to_file  = (ex_op inside {OP_BIT_CLR, OP_BIT_SET})
	                  || ((ex_op inside {OP_ADD_FILE, OP_AND_FILE}) && ex_d);
	assign hit         = (paddr[1:0] == 2'b00) && (paddr <= OFS_SKIP);
	assign rd_f        = is_instr_wr ? ex_f : st_ff.faddr;

	// ----------------------------------------------------------------
	// File view: special addresses over the RAM
	// ----------------------------------------------------------------
	always_comb
	begin
		unique case (rd_f)
			FA_PCL:    fval = st_ff.pc[7:0];
			FA_STATUS: fval = {5'h00, st_ff.flags};
			FA_PORT1:  fval = port_in;
			default:   fval = ram_rdata;
		endcase
	end

	bcx_file_ram u_ram (
		.pclk    (pclk),
		.presetn (presetn),
		.raddr   (rd_f),
		.we      (ram_we),
		.waddr   (wr_addr),
		.wdata   (wr_data),
		.rdata   (ram_rdata)
	);

	bcx_alu u_alu (
		.op   (ex_op),
		.acc  (st_ff.acc),
		.fval (fval),
		.lit  (ex_k),
		.bsel (ex_b),
		.res  (alu)
	);

	assign take_skip = exec && (((ex_op == OP_TEST_CLR) && !fval[ex_b])
	                 || ((ex_op == OP_TEST_SET) && fval[ex_b]));

	// ----------------------------------------------------------------
	// File write port
	// ----------------------------------------------------------------
	always_comb
	begin
		wr_en   = 1'b0;
		wr_addr = st_ff.faddr;
		wr_data = pwdata[7:0];
		if (access && (st_ff.state == ST_READ) && pwrite)
		begin
			if (is_instr_wr)
			begin
				wr_en   = ex_to_file;
				wr_addr = ex_f;
				wr_data = alu.res;
			end
			else
			begin
				wr_en = (paddr == OFS_FDATA);
			end
		end
	end

	assign ram_we = wr_en && !(wr_addr inside {FA_PCL, FA_STATUS, FA_PORT1});

	// ----------------------------------------------------------------
	// Control and execute
	// ----------------------------------------------------------------
	always_comb
	begin
		nxt_st           = st_ff;
		nxt_st.presc_clr = 1'b0;
		unique case (st_ff.state)
			ST_IDLE:
			begin
				nxt_st.pready = 1'b0;
				if (access)
				begin
					nxt_st.state = ST_READ;
				end
			end
			ST_READ:
			begin
				nxt_st.state   = ST_DONE;
				nxt_st.pready  = 1'b1;
				nxt_st.pslverr = !hit;
				nxt_st.prdata  = 32'h0000_0000;
				if (wr_en)
				begin
					unique case (wr_addr)
						FA_PCL:    nxt_st.pc = {st_ff.pc[10:9], 1'b0, wr_data};
						FA_STATUS: nxt_st.flags = wr_data[2:0];
						FA_PORT1:  nxt_st.port_out = wr_data;
						default:   nxt_st.port_out = st_ff.port_out;
					endcase
				end
				if (exec)
				begin
					nxt_st.instr = ex_instr;
					nxt_st.skip  = take_skip;
					if (!(wr_en && (wr_addr == FA_PCL)))
					begin
						nxt_st.pc = st_ff.pc + 11'h001;
					end
					if ((ex_op inside {OP_ADD_FILE, OP_AND_FILE}) && !ex_d)
					begin
						nxt_st.acc = alu.res;
					end
					if (ex_op == OP_AND_LIT)
					begin
						nxt_st.acc = alu.res;
					end
					if (ex_op inside {OP_ADD_FILE, OP_AND_FILE, OP_AND_LIT})
					begin
						nxt_st.flags[BIT_ZERO] = alu.z;
					end
					if (ex_op == OP_ADD_FILE)
					begin
						nxt_st.flags[BIT_CARRY] = alu.c;
						nxt_st.flags[BIT_DIGIT] = alu.dc;
					end
					if ((ex_op == OP_DIR_LOAD) && (ex_instr[2:0] == DIR_PORT1))
					begin
						nxt_st.port_oe = ~st_ff.acc;
					end
					if (ex_op == OP_BRANCH)
					begin
						nxt_st.pc = {st_ff.pc[10:9], ex_instr[8:0]};
					end
					nxt_st.presc_clr = ex_to_file && (ex_f == FA_TIMER) && st_ff.psa_tmr;
				end
				else if (pwrite)
				begin
					unique case (paddr)
						OFS_ACC:    nxt_st.acc = pwdata[7:0];
						OFS_STATUS: nxt_st.flags = pwdata[2:0];
						OFS_PC:     nxt_st.pc = pwdata[10:0];
						OFS_FADDR:  nxt_st.faddr = pwdata[4:0];
						OFS_CTRL:   nxt_st.psa_tmr = pwdata[BIT_PSA_TMR];
						default:    nxt_st.skip = st_ff.skip;
					endcase
				end
				else
				begin
					unique case (paddr)
						OFS_INSTR:  nxt_st.prdata = {20'h00000, st_ff.instr};
						OFS_ACC:    nxt_st.prdata = {24'h000000, st_ff.acc};
						OFS_STATUS: nxt_st.prdata = {29'h00000000, st_ff.flags};
						OFS_PC:     nxt_st.prdata = {21'h000000, st_ff.pc};
						OFS_FADDR:  nxt_st.prdata = {27'h0000000, st_ff.faddr};
						OFS_FDATA:  nxt_st.prdata = {24'h000000, fval};
						OFS_CTRL:   nxt_st.prdata = {31'h00000000, st_ff.psa_tmr};
						OFS_SKIP:   nxt_st.prdata = {31'h00000000, st_ff.skip};
						default:    nxt_st.prdata = 32'h0000_0000;
					endcase
				end
			end
			ST_DONE:
			begin
				nxt_st.state  = ST_IDLE;
				nxt_st.pready = 1'b0;
			end
			default:
			begin
				nxt_st.state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_ff <= CORE_RST;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign pready    = st_ff.pready;
	assign prdata    = st_ff.prdata;
	assign pslverr   = st_ff.pslverr;
	assign port_out  = st_ff.port_out;
	assign port_oe   = st_ff.port_oe;
	assign presc_clr = st_ff.presc_clr;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [8:0] chk_sum;
	logic [7:0] chk_mask;
	logic [4:0] chk_lo;
	assign chk_sum  = {1'b0, st_ff.acc} + {1'b0, fval};
	assign chk_lo   = {1'b0, st_ff.acc[3:0]} + {1'b0, fval[3:0]};
	assign chk_mask = 8'h01 << ex_b;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence seq_skip_armed;
		take_skip ##1 st_ff.skip;
	endsequence

	sequence seq_skip_consumed;
		exec && st_ff.skip;
	endsequence

	AST_PC_BIT_NINE: assert property (exec && ex_to_file && (ex_f == FA_PCL) |=> !st_ff.pc[BIT_PC_NINE])
		else $error("pc bit eight not cleared on file write");
	AST_BRANCH_KEEP: assert property (exec && (ex_op == OP_BRANCH) |=> st_ff.pc[8:0] == $past(ex_instr[8:0]))
		else $error("branch target not loaded intact");
	AST_PIN_SOURCE: assert property (exec && (ex_op == OP_BIT_SET) && (ex_f == FA_PORT1)
		|=> st_ff.port_out == ($past(port_in) | $past(chk_mask)))
		else $error("port update not based on pins");
	AST_DIR_LOAD: assert property (exec && (ex_op == OP_DIR_LOAD) && (ex_instr[2:0] == DIR_PORT1)
		|=> st_ff.port_oe == ~$past(st_ff.acc))
		else $error("direction latch not loaded from accumulator");
	AST_DIR_OTHER: assert property (exec && (ex_op == OP_DIR_LOAD) && (ex_instr[2:0] != DIR_PORT1)
		|=> $stable(port_oe))
		else $error("direction latch changed by other operand");
	AST_PRESC_CLR: assert property (exec && ex_to_file && (ex_f == FA_TIMER) && st_ff.psa_tmr
		|=> presc_clr ##1 !presc_clr)
		else $error("prescaler clear pulse wrong");
	AST_PRESC_QUIET: assert property (presc_clr
		|-> $past(exec && ex_to_file && (ex_f == FA_TIMER) && st_ff.psa_tmr))
		else $error("prescaler cleared without cause");
	AST_ADD_FLAGS: assert property (exec && (ex_op == OP_ADD_FILE)
		|=> st_ff.flags[BIT_CARRY] == $past(chk_sum[8])
		&& st_ff.flags[BIT_DIGIT] == $past(chk_lo[4])
		&& st_ff.flags[BIT_ZERO] == ($past(chk_sum[7:0]) == 8'h00))
		else $error("add flags wrong");
	AST_DEST_ACC: assert property (exec && (ex_op == OP_AND_FILE) && !ex_d
		|=> st_ff.acc == ($past(st_ff.acc) & $past(fval)))
		else $error("and result not in accumulator");
	AST_AND_ZERO: assert property (exec && (ex_op == OP_AND_FILE)
		|=> st_ff.flags[BIT_ZERO] == (($past(st_ff.acc) & $past(fval)) == 8'h00))
		else $error("and zero flag wrong");
	AST_DEST_FILE: assert property (exec && (ex_op == OP_ADD_FILE) && ex_d |=> $stable(st_ff.acc))
		else $error("accumulator changed with file destination");
	AST_AND_LIT: assert property (exec && (ex_op == OP_AND_LIT)
		|=> st_ff.acc == ($past(st_ff.acc) & $past(ex_k)) && st_ff.flags[BIT_ZERO] == (st_ff.acc == 8'h00))
		else $error("literal and wrong");
	AST_BIT_FLAGS: assert property (exec && (ex_op inside {OP_BIT_CLR, OP_BIT_SET,
		OP_TEST_CLR, OP_TEST_SET}) |=> $stable(st_ff.flags))
		else $error("bit instruction changed flags");
	AST_SKIP_ARM: assert property (exec && (ex_op == OP_TEST_CLR) && !fval[ex_b] |-> seq_skip_armed)
		else $error("skip when clear not armed");
	AST_SKIP_DISCARD: assert property (seq_skip_consumed
		|=> $stable(st_ff.acc) && $stable(st_ff.flags) && !st_ff.skip)
		else $error("skipped instruction not discarded");
	AST_SKIP_SET: assert property (exec && (ex_op == OP_TEST_SET) |=> st_ff.skip == $past(fval[ex_b]))
		else $error("skip when set wrong");

endmodule : bcx_core

// ===== hw/bcx_file_ram.sv
/*
 * File register storage, 32 bytes, one write port and one registered read port.
 * Assumes read and write addresses are stable around the rising edge of pclk.
 */
`timescale 1ns/1ns
module bcx_file_ram (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [4:0]  raddr,
	input  wire logic        we,
	input  wire logic [4:0]  waddr,
	input  wire logic [7:0]  wdata,
	output logic      [7:0]  rdata
);
	import bcx_pkg::*;

	bcx_ram_s st_ff;
	bcx_ram_s nxt_st;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	always_comb
	begin
		nxt_st       = st_ff;
		nxt_st.rdata = st_ff.mem[raddr];
		if (we)
		begin
			nxt_st.mem[waddr] = wdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_ff <= '0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign rdata = st_ff.rdata;

endmodule : bcx_file_ram

// ===== pkg/bcx_pkg.sv
/*
 * Shared constants, types and reset values for the baseline core execute block.
 * Assumes a single APB clock domain and an 8-bit data path with 32 file addresses.
 */
package bcx_pkg;

	// ----------------------------------------------------------------
	// Clock and sizes
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned FILE_DEPTH    = 32;

	// ----------------------------------------------------------------
	// APB register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_INSTR  = 8'h00;
	localparam logic [7:0] OFS_ACC    = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_PC     = 8'h0c;
	localparam logic [7:0] OFS_FADDR  = 8'h10;
	localparam logic [7:0] OFS_FDATA  = 8'h14;
	localparam logic [7:0] OFS_CTRL   = 8'h18;
	localparam logic [7:0] OFS_SKIP   = 8'h1c;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned BIT_CARRY   = 0;
	localparam int unsigned BIT_DIGIT   = 1;
	localparam int unsigned BIT_ZERO    = 2;
	localparam int unsigned BIT_PSA_TMR = 0;
	localparam int unsigned BIT_PC_NINE = 8;

	// ----------------------------------------------------------------
	// Special file addresses
	// ----------------------------------------------------------------
	localparam logic [4:0] FA_TIMER  = 5'h01;
	localparam logic [4:0] FA_PCL    = 5'h02;
	localparam logic [4:0] FA_STATUS = 5'h03;
	localparam logic [4:0] FA_PORT1  = 5'h05;
	localparam logic [2:0] DIR_PORT1 = 3'h6;

	// ----------------------------------------------------------------
	// Opcode fields
	// ----------------------------------------------------------------
	localparam logic [5:0] OPC_ADD_FILE = 6'h07;
	localparam logic [5:0] OPC_AND_FILE = 6'h05;
	localparam logic [3:0] OPC_BIT_CLR  = 4'h4;
	localparam logic [3:0] OPC_BIT_SET  = 4'h5;
	localparam logic [3:0] OPC_TEST_CLR = 4'h6;
	localparam logic [3:0] OPC_TEST_SET = 4'h7;
	localparam logic [3:0] OPC_AND_LIT  = 4'he;
	localparam logic [2:0] OPC_BRANCH   = 3'h5;
	localparam logic [8:0] OPC_DIR_LOAD = 9'h000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NONE, OP_ADD_FILE, OP_AND_FILE, OP_AND_LIT, OP_BIT_CLR,
		OP_BIT_SET, OP_TEST_CLR, OP_TEST_SET, OP_DIR_LOAD, OP_BRANCH
	} bcx_op_e;

	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_DONE} bcx_fsm_e;

	typedef struct packed {
		logic [7:0] res;
		logic       c;
		logic       dc;
		logic       z;
	} bcx_alu_s;

	typedef struct packed {
		logic [FILE_DEPTH-1:0][7:0] mem;
		logic [7:0]                 rdata;
	} bcx_ram_s;

	typedef struct packed {
		bcx_fsm_e    state;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
		logic [11:0] instr;
		logic [7:0]  acc;
		logic [2:0]  flags;
		logic [10:0] pc;
		logic [4:0]  faddr;
		logic        psa_tmr;
		logic        skip;
		logic [7:0]  port_out;
		logic [7:0]  port_oe;
		logic        presc_clr;
	} bcx_core_s;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [10:0] RST_PC      = 11'h000;
	localparam logic [7:0]  RST_PORT_OE = 8'h00;
	localparam bcx_core_s   CORE_RST    = '{state: ST_IDLE, pc: RST_PC, port_oe: RST_PORT_OE, default: '0};

endpackage : bcx_pkg
